/* shared/cpcfg_regs.svh */
// register offsets, field positions, reset values and timing counts of the power config bank
`ifndef CPCFG_REGS_SVH
`define CPCFG_REGS_SVH

`define CPCFG_ADDR_W 8
`define CPCFG_DATA_W 8

`define CPCFG_OFF_IN_EN 8'h73
`define CPCFG_OFF_SLOT_EN 8'h74
`define CPCFG_OFF_PWR 8'h75
`define CPCFG_OFF_STS0 8'h76

`define CPCFG_RST_IN_EN 8'hFC
`define CPCFG_RST_SLOT_EN 8'h00
`define CPCFG_RST_PWR 8'h00
`define CPCFG_RST_STS0 8'h00

// channel one sits in bit 7, channel two in bit 6, in the input enable, slot enable and status registers
`define CPCFG_BIT_CH1 7
`define CPCFG_BIT_CH2 6
`define CPCFG_BIT_MIC_BIAS 7
`define CPCFG_BIT_CONV 6
`define CPCFG_BIT_LOOP 5
`define CPCFG_BIT_LIVE 4
// read-only reserved bit of the power register
`define CPCFG_BIT_PWR_RO 0

`define CPCFG_CLK_NS 50
`define CPCFG_SETTLE_NS 500
`define CPCFG_SETTLE_CYC ((`CPCFG_SETTLE_NS + `CPCFG_CLK_NS - 1) / `CPCFG_CLK_NS)

`endif

/* shared/cpcfg_pkg.sv */
// types shared by the power config bank modules
package cpcfg_pkg;
  typedef enum logic [1:0] {PS_OFF, PS_SETTLE, PS_ON} cpcfg_pwr_state_t;
  typedef logic [7:0] cpcfg_byte_t;
endpackage

/* rtl/cpcfg_chan_power.sv */
// one converter channel: supply switch and settle tracking for its powered status
`timescale 1ns/1ns
`include "cpcfg_regs.svh"
module cpcfg_chan_power #(
  parameter int SETTLE_CYCLES = `CPCFG_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic want_on_i,
  output logic supply_on_o,
  output logic powered_o,
  output cpcfg_pkg::cpcfg_pwr_state_t state_o
);
  import cpcfg_pkg::*;

  localparam int CW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);

  cpcfg_pwr_state_t state_r;
  cpcfg_pwr_state_t state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // powering down is immediate; status only claims power once the supply has settled
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      PS_OFF: begin
        cnt_nxt = '0;
        if (want_on_i) begin
          state_nxt = PS_SETTLE;
        end
      end
      PS_SETTLE: begin
        cnt_nxt = cnt_r + CW'(1);
        if (!want_on_i) begin
          state_nxt = PS_OFF;
        end else if (cnt_r == LAST) begin
          state_nxt = PS_ON;
        end
      end
      PS_ON: begin
        if (!want_on_i) begin
          state_nxt = PS_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= PS_OFF;
      cnt_r <= '0;
      supply_on_o <= 1'b0;
      powered_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      supply_on_o <= want_on_i;
      powered_o <= (state_nxt == PS_ON);
    end
  end

  assign state_o = state_r;
endmodule

/* rtl/cpcfg_slot_drive.sv */
// serial output slot driver: drives the slot or leaves it in high impedance
`timescale 1ns/1ns
module cpcfg_slot_drive (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic drive_i,
  input wire logic data_i,
  output logic data_o,
  output logic oe_o
);
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_o <= 1'b0;
      oe_o <= 1'b0;
    end else begin
      data_o <= drive_i & data_i;
      oe_o <= drive_i;
    end
  end
endmodule

/* rtl/cpcfg_top.sv */
// channel enable and power configuration register bank of a two-channel audio converter
//
// Overview of operation
// R1: input enable bit 7 turns channel one on
// R2: input enable bit 6 turns channel two on
// R3: slot enable bit 7 drives slot one, else high-z
// R4: slot enable bit 6 drives slot two, else high-z
// R5: power bit 7 switches microphone bias power
// R6: power bit 6 powers enabled channels, else all off
// R7: power bit 5 switches loop power
// R8: live control off: no channel changes while recording
// R9: live control on: each channel follows its enable
// R10: host keeps channel one on during live control
// R11: host writes reserved fields only with reset values
// R12: status bits 7 and 6 show channel powered
// R13: reset restores every register before first access
`timescale 1ns/1ns
`include "cpcfg_regs.svh"
module cpcfg_top #(
  parameter int SETTLE_CYCLES = `CPCFG_SETTLE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wdata_i,
  input wire logic rd_en_i,
  input wire logic [1:0] slot_data_i,
  output cpcfg_pkg::cpcfg_byte_t rdata_o,
  output logic microphone_bias_power_on_o,
  output logic loop_power_on_o,
  output logic [1:0] converter_supply_o,
  output logic [1:0] slot_data_o,
  output logic [1:0] slot_oe_o
);
  import cpcfg_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register storage

  cpcfg_byte_t in_en_r;
  cpcfg_byte_t slot_en_r;
  cpcfg_byte_t pwr_r;
  cpcfg_byte_t rdata_nxt;
  logic [1:0] powered;
  logic [1:0] supply;
  logic [1:0] want_on;
  logic [1:0] input_on;
  logic [1:0] slot_drive;
  logic wr_in;
  logic wr_slot;
  logic wr_pwr;
  logic microphone_bias_power_on;
  logic converter_power_on;
  logic loop_power_on;
  logic live_channel_power_ctl;
  logic any_recording;
  cpcfg_byte_t sts0;

  assign wr_in = wr_en_i && hit(addr_i, `CPCFG_OFF_IN_EN);
  assign wr_slot = wr_en_i && hit(addr_i, `CPCFG_OFF_SLOT_EN);
  assign wr_pwr = wr_en_i && hit(addr_i, `CPCFG_OFF_PWR);

  // reserved bits except power bit 0 are kept as written so a read returns what the host put there
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_en_r <= `CPCFG_RST_IN_EN; // R13
      slot_en_r <= `CPCFG_RST_SLOT_EN; // R13
      pwr_r <= `CPCFG_RST_PWR; // R13
    end else begin
      if (wr_in) begin
        in_en_r <= wdata_i; // R1 R2
      end
      if (wr_slot) begin
        slot_en_r <= wdata_i; // R3 R4
      end
      if (wr_pwr) begin
        pwr_r <= wdata_i & ~(8'h01 << `CPCFG_BIT_PWR_RO); // R11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // field decode

  assign input_on = {in_en_r[`CPCFG_BIT_CH2], in_en_r[`CPCFG_BIT_CH1]}; // R1 R2
  assign slot_drive = {slot_en_r[`CPCFG_BIT_CH2], slot_en_r[`CPCFG_BIT_CH1]};
  assign microphone_bias_power_on = pwr_r[`CPCFG_BIT_MIC_BIAS];
  assign converter_power_on = pwr_r[`CPCFG_BIT_CONV];
  assign loop_power_on = pwr_r[`CPCFG_BIT_LOOP];
  assign live_channel_power_ctl = pwr_r[`CPCFG_BIT_LIVE];
  assign any_recording = |supply;

  ////////////////////////////////////////////////////////////////////////////////
  // channel power decision

  // without live control a running set of channels is frozen; a changed enable
  // only takes effect after the host drops converter power and raises it again, or turns live control on
  assign want_on = !converter_power_on ? 2'b00 : // R6
                   live_channel_power_ctl ? input_on : // R9
                   any_recording ? supply : input_on; // R8

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      cpcfg_chan_power #(
        .SETTLE_CYCLES(SETTLE_CYCLES)
      ) u_power (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .want_on_i(want_on[g]),
        .supply_on_o(supply[g]),
        .powered_o(powered[g]),
        .state_o()
      );
      cpcfg_slot_drive u_slot (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .drive_i(slot_drive[g]), // R3 R4
        .data_i(slot_data_i[g]),
        .data_o(slot_data_o[g]),
        .oe_o(slot_oe_o[g])
      );
    end
  endgenerate

  assign converter_supply_o = supply;

  ////////////////////////////////////////////////////////////////////////////////
  // block power and read path

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      microphone_bias_power_on_o <= 1'b0;
      loop_power_on_o <= 1'b0;
    end else begin
      microphone_bias_power_on_o <= microphone_bias_power_on; // R5
      loop_power_on_o <= loop_power_on; // R7
    end
  end

  assign sts0 = {powered[0], powered[1], 6'h00}; // R12

  // unmapped offsets read as zero
  assign rdata_nxt = hit(addr_i, `CPCFG_OFF_IN_EN) ? in_en_r :
                     hit(addr_i, `CPCFG_OFF_SLOT_EN) ? slot_en_r :
                     hit(addr_i, `CPCFG_OFF_PWR) ? pwr_r :
                     hit(addr_i, `CPCFG_OFF_STS0) ? sts0 : 8'h00;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_en_i) begin
      rdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wr_in;
    wr_en_i && addr_i == `CPCFG_OFF_IN_EN;
  endsequence

  sequence s_conv_off;
    !converter_power_on;
  endsequence

  property p_reset_values;
    @(posedge ref_clk_i)
    $fell(reset_i) |-> in_en_r == 8'hFC && slot_en_r == 8'h00 && pwr_r == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bank not at reset values"); // R13

  property p_in_write;
    @(posedge ref_clk_i) disable iff (reset_i)
    s_wr_in |=> input_on == {$past(wdata_i[6]), $past(wdata_i[7])};
  endproperty
  a_in_write: assert property (p_in_write) else $error("input enable not stored"); // R1 R2

  property p_slot_follow;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_slot |=> ##1 slot_oe_o == {$past(wdata_i[6], 2), $past(wdata_i[7], 2)};
  endproperty
  a_slot_follow: assert property (p_slot_follow) else $error("slot drive mismatch"); // R3 R4

  property p_bias;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_pwr |=> ##1 microphone_bias_power_on_o == $past(wdata_i[7], 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias power mismatch"); // R5

  property p_loop;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_pwr |=> ##1 loop_power_on_o == $past(wdata_i[5], 2);
  endproperty
  a_loop: assert property (p_loop) else $error("loop power mismatch"); // R7

  property p_conv_off;
    @(posedge ref_clk_i) disable iff (reset_i)
    s_conv_off |=> converter_supply_o == 2'b00 ##1 powered == 2'b00;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("channels left on"); // R6

  property p_frozen;
    @(posedge ref_clk_i) disable iff (reset_i)
    converter_power_on && !live_channel_power_ctl && |converter_supply_o
      |=> converter_supply_o == $past(converter_supply_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("channel changed while recording"); // R8

  property p_live;
    @(posedge ref_clk_i) disable iff (reset_i)
    converter_power_on && live_channel_power_ctl |=> converter_supply_o == $past(input_on);
  endproperty
  a_live: assert property (p_live) else $error("live channel not following enable"); // R9

  property p_status;
    @(posedge ref_clk_i) disable iff (reset_i)
    rd_en_i && addr_i == `CPCFG_OFF_STS0 |=> rdata_o == {$past(powered[0]), $past(powered[1]), 6'h00};
  endproperty
  a_status: assert property (p_status) else $error("status read mismatch"); // R12

  property p_powered_supply;
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(powered[0]) |-> converter_supply_o[0] && $past(converter_supply_o[0], SETTLE_CYCLES);
  endproperty
  a_powered_supply: assert property (p_powered_supply) else $error("status before settle"); // R12

  property p_status_drop;
    @(posedge ref_clk_i) disable iff (reset_i)
    $fell(converter_supply_o[0]) |-> !powered[0];
  endproperty
  a_status_drop: assert property (p_status_drop) else $error("status kept after supply off"); // R12

  sequence s_rd_sts;
    rd_en_i && addr_i == `CPCFG_OFF_STS0;
  endsequence

  property p_sts_reserved;
    @(posedge ref_clk_i) disable iff (reset_i)
    s_rd_sts |=> rdata_o[5:0] == 6'h00;
  endproperty
  a_sts_reserved: assert property (p_sts_reserved) else $error("status reserved bits set"); // R12

  property p_sts_write;
    @(posedge ref_clk_i) disable iff (reset_i)
    wr_en_i && addr_i == `CPCFG_OFF_STS0 |=> $stable(in_en_r) && $stable(slot_en_r) && $stable(pwr_r);
  endproperty
  a_sts_write: assert property (p_sts_write) else $error("status write changed a register"); // R12

  property p_rd_hold;
    @(posedge ref_clk_i) disable iff (reset_i)
    !rd_en_i |=> $stable(rdata_o);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read"); // R12

  property p_conv_on;
    @(posedge ref_clk_i) disable iff (reset_i)
    converter_power_on && !live_channel_power_ctl && !any_recording
      |=> converter_supply_o == $past(input_on);
  endproperty
  a_conv_on: assert property (p_conv_on) else $error("enabled channels not powered"); // R6

  property p_slot_quiet;
    @(posedge ref_clk_i) disable iff (reset_i)
    (slot_data_o & ~slot_oe_o) == 2'b00;
  endproperty
  a_slot_quiet: assert property (p_slot_quiet) else $error("undriven slot shows data"); // R3 R4

  ////////////////////////////////////////////////////////////////////////////////
  // settle tracking for the status checks

  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SW-1:0] SFULL = SW'(SETTLE_CYCLES);

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_settle_chk
      logic [SW-1:0] on_cnt_r;
      // counts supply cycles up to the settle length; a dropped supply starts it over
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
          on_cnt_r <= '0;
        end else if (!converter_supply_o[k]) begin
          on_cnt_r <= '0;
        end else if (on_cnt_r != SFULL) begin
          on_cnt_r <= on_cnt_r + SW'(1);
        end
      end

      property p_status_settled;
        @(posedge ref_clk_i) disable iff (reset_i)
        powered[k] |-> converter_supply_o[k] && on_cnt_r == SFULL;
      endproperty
      a_status_settled: assert property (p_status_settled) else $error("status early"); // R12

      property p_status_rises;
        @(posedge ref_clk_i) disable iff (reset_i)
        converter_supply_o[k] && on_cnt_r == SFULL |-> powered[k];
      endproperty
      a_status_rises: assert property (p_status_rises) else $error("status late"); // R12
    end
  endgenerate
endmodule

/* tb/cpcfg_host.sv */
// host controller model driving the strobe register port of the bank
`timescale 1ns/1ns
`include "cpcfg_regs.svh"
module cpcfg_host (
  input wire logic ref_clk_i,
  input cpcfg_pkg::cpcfg_byte_t rdata_i,
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic [7:0] wdata_o,
  output logic rd_en_o
);
  import cpcfg_pkg::*;
  logic live_r;
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    wdata_o = 8'h00;
    rd_en_o = 1'b0;
    live_r = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // reserved fields always carry their reset values
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    case (a)
      `CPCFG_OFF_IN_EN: legal = {d[7] | live_r, d[6], 6'h3C};
      `CPCFG_OFF_SLOT_EN: legal = {d[7:6], 6'h00};
      `CPCFG_OFF_PWR: legal = {d[7:4], 4'h0};
      default: legal = d;
    endcase
  endfunction
  // strobe launched and released at falling edges, so it spans exactly one rising edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    wdata_o = legal(a, d);
    wr_en_o = 1'b1;
    if (a == `CPCFG_OFF_PWR) begin
      live_r = d[`CPCFG_BIT_LIVE];
    end
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
    // released data no longer shows the last value
    wdata_o = ~wdata_o;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    rd_en_o = 1'b1;
    @(negedge ref_clk_i);
    rd_en_o = 1'b0;
    d = rdata_i;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench of the channel enable and power configuration bank
`timescale 1ns/1ns
`include "cpcfg_regs.svh"
module testbench;
  import cpcfg_pkg::*;
  localparam int SETTLE = 2;
  logic ref_clk_i, reset_i, wr_en, rd_en;
  logic [7:0] addr, wdata;
  logic [1:0] slot_in, supply, sdo, soe;
  cpcfg_byte_t rdata;
  logic bias, loop;
  logic [7:0] pins;
  int errors, n_tests;
  assign pins = {bias, loop, supply, sdo, soe};
  cpcfg_top #(.SETTLE_CYCLES(SETTLE)) uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .addr_i(addr), .wr_en_i(wr_en), .wdata_i(wdata), .rd_en_i(rd_en),
    .slot_data_i(slot_in), .rdata_o(rdata), .microphone_bias_power_on_o(bias),
    .loop_power_on_o(loop), .converter_supply_o(supply), .slot_data_o(sdo),
    .slot_oe_o(soe));
  cpcfg_host host (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr), .wr_en_o(wr_en),
    .wdata_o(wdata), .rd_en_o(rd_en));
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check($sformatf("reg %h", a), d, exp);
  endtask
  task automatic wr_wait(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    // supply follows one cycle after the register, status after the settle count
    repeat (SETTLE + 4) @(negedge ref_clk_i);
  endtask
  task automatic finish_test;
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    slot_in = 2'b11;
    reset_i = 1'b1;
    repeat (12) @(negedge ref_clk_i);
    reset_i = 1'b0;
    rd_chk(`CPCFG_OFF_IN_EN, 8'hFC);
    rd_chk(`CPCFG_OFF_SLOT_EN, 8'h00);
    rd_chk(`CPCFG_OFF_PWR, 8'h00);
    rd_chk(`CPCFG_OFF_STS0, 8'h00);
    check("pins", pins, 8'h00);
    rd_chk(8'h77, 8'h00);
    // status is read-only: a write must leave it alone
    wr_wait(`CPCFG_OFF_STS0, 8'hC0);
    rd_chk(`CPCFG_OFF_STS0, 8'h00);
    wr_wait(`CPCFG_OFF_SLOT_EN, 8'h80);
    check("pins", pins, 8'h05);
    slot_in = 2'b10;
    wr_wait(`CPCFG_OFF_SLOT_EN, 8'h40);
    check("pins", pins, 8'h0A);
    rd_chk(`CPCFG_OFF_SLOT_EN, 8'h40);
    wr_wait(`CPCFG_OFF_PWR, 8'hA0);
    check("pins", pins, 8'hCA);
    rd_chk(`CPCFG_OFF_PWR, 8'hA0);
    wr_wait(`CPCFG_OFF_PWR, 8'hF0);
    check("pins", pins, 8'hFA);
    rd_chk(`CPCFG_OFF_STS0, 8'hC0);
    // live control: channel two drops alone, channel one stays up
    wr_wait(`CPCFG_OFF_IN_EN, 8'hBC);
    check("pins", pins, 8'hDA);
    rd_chk(`CPCFG_OFF_STS0, 8'h80);
    // live control off while recording: enabling channel two changes nothing
    wr_wait(`CPCFG_OFF_PWR, 8'hE0);
    wr_wait(`CPCFG_OFF_IN_EN, 8'hFC);
    check("pins", pins, 8'hDA);
    rd_chk(`CPCFG_OFF_IN_EN, 8'hFC);
    wr_wait(`CPCFG_OFF_PWR, 8'h20);
    check("pins", pins, 8'h4A);
    rd_chk(`CPCFG_OFF_STS0, 8'h00);
    wr_wait(`CPCFG_OFF_IN_EN, 8'h7C);
    wr_wait(`CPCFG_OFF_PWR, 8'hC0);
    check("pins", pins, 8'hAA);
    rd_chk(`CPCFG_OFF_STS0, 8'h40);
    // a second reset while channel two and both slots are live brings everything back
    wr_wait(`CPCFG_OFF_SLOT_EN, 8'hC0);
    check("pins", pins, 8'hAB);
    reset_i = 1'b1;
    repeat (3) @(negedge ref_clk_i);
    reset_i = 1'b0;
    check("pins", pins, 8'h00);
    rd_chk(`CPCFG_OFF_IN_EN, 8'hFC);
    rd_chk(`CPCFG_OFF_SLOT_EN, 8'h00);
    rd_chk(`CPCFG_OFF_PWR, 8'h00);
    rd_chk(`CPCFG_OFF_STS0, 8'h00);
    finish_test();
  end
endmodule
